// ---- rtl/slsg_pkg.sv ----
package slsg_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_BRDELAY = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
  // cfg fields
  localparam int CFG_RAMP_SUP = 0;
  localparam int CFG_STOPB = 1;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // irq fields
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_TCUT = 1;
  localparam int IRQ_LVL = 2;
  localparam int IRQ_W = 3;
  // timing defaults, in clock cycles
  localparam logic [31:0] DELAY_RST = 32'h0000_0064;
  localparam logic [31:0] BRDELAY_RST = 32'h0000_0064;
  typedef enum logic [2:0] {
    SLSG_IDLE, SLSG_WAIT, SLSG_RAMP, SLSG_LEVEL, SLSG_TRIP
  } slsg_state_t;
endpackage

// ---- rtl/slsg_top.sv ----
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - fault during controlled stop cuts torque at once
// - guard off: run and stop commands pass unrestricted
// - guard selected: clamp speed, brake on quick-stop ramp
// - configuration bit chooses brake-ramp supervision or none
// - guard deselected: clamping and monitoring both stop
// - speed below limit: follow setpoint, monitor after delay
// - speed above limit: brake, monitor after delay; release once speed reaches limit
// - four levels, changed only from fieldbus control word one
// - lower level with ramp supervision: brake, ramp monitor after delay
// - ramp hands over on ramp reaching level or speed+ramp delay
// - lower level without supervision: brake, level monitor after delay
// - higher level applies at once
// - active level reported in fieldbus status word
// - coast stop while guard active: safe torque off at once
// - guard fault: immediate or ramped torque cut by configuration
module slsg_top #(
  parameter int SPW = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_guard_sel_di,
  input wire logic i_guard_sel_bus,
  input wire logic [1:0] i_bus_level,
  input wire logic i_stop_active,
  input wire logic i_monitor_fault,
  input wire logic i_coast_stop,
  input wire logic [SPW-1:0] i_speed_abs,
  input wire logic [SPW-1:0] i_ramp_value,
  input wire logic [4*SPW-1:0] i_level_limits,
  input wire logic i_run_command,
  output logic o_run_enable,
  output logic o_speed_clamp,
  output logic o_brake_quick,
  output logic o_monitor_level,
  output logic o_monitor_ramp,
  output logic [SPW-1:0] o_limit,
  output logic o_torque_off_now,
  output logic o_torque_off_ramped,
  output logic [1:0] o_active_level,
  output logic o_irq
);
  import slsg_pkg::*;
  if (SPW < 2 || SPW > 32) begin
    $error("SPW out of range");
  end

  function automatic logic [SPW-1:0] lim_of(input logic [4*SPW-1:0] v,
                                            input logic [1:0] l);
    lim_of = v[l*SPW +: SPW];
  endfunction

  // ----------------------------------------------------------------
  // registers over apb
  // ----------------------------------------------------------------
  logic [31:0] cfg_q, cfg_d, dly_q, dly_d, brd_q, brd_d;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
  logic [31:0] rd_d, rd_q;
  logic wr, rd;
  slsg_state_t st_q, st_d;
  logic [1:0] lvl_q, lvl_d;
  logic [31:0] cnt_q, cnt_d, bcnt_q, bcnt_d;
  logic sel_q, sel_d, brk_q, brk_d;

  // zero-wait slave: answer in the access cycle
  assign o_pready = 1'b1;
  assign wr = i_psel && i_penable && i_pwrite && i_ce;
  assign rd = i_psel && !i_penable && !i_pwrite;
  assign o_pslverr = i_psel && i_penable && (i_paddr > OFS_IRQ_CLR ||
                     i_paddr[1:0] != 2'b00);
  assign o_prdata = rd_q;

  always_comb begin
    cfg_d = cfg_q;
    dly_d = dly_q;
    brd_d = brd_q;
    ien_d = ien_q;
    // set wins over clear
    ist_d = ist_q;
    if (wr && i_paddr == OFS_IRQ_CLR) begin
      ist_d = ist_q & ~i_pwdata[IRQ_W-1:0];
    end
    ist_d = ist_d | ev;
    if (wr) begin
      unique case (i_paddr)
        OFS_CFG: cfg_d = i_pwdata;
        OFS_DELAY: dly_d = i_pwdata;
        OFS_BRDELAY: brd_d = i_pwdata;
        OFS_IRQ_EN: ien_d = i_pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    rd_d = rd_q;
    if (rd) begin
      unique case (i_paddr)
        OFS_CFG: rd_d = cfg_q;
        OFS_DELAY: rd_d = dly_q;
        OFS_BRDELAY: rd_d = brd_q;
        OFS_STATUS: rd_d = {24'h0, 1'b0, 3'(st_q), lvl_q, brk_q, sel_q};
        OFS_IRQ_STAT: rd_d = {{(32-IRQ_W){1'b0}}, ist_q};
        OFS_IRQ_EN: rd_d = {{(32-IRQ_W){1'b0}}, ien_q};
        default: rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= CFG_RST;
      dly_q <= DELAY_RST;
      brd_q <= BRDELAY_RST;
      ist_q <= '0;
      ien_q <= '0;
      rd_q <= 32'h0;
    end else if (i_ce) begin
      cfg_q <= cfg_d;
      dly_q <= dly_d;
      brd_q <= brd_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      rd_q <= rd_d;
    end
  end
  assign o_irq = |(ist_q & ien_q);

  // ----------------------------------------------------------------
  // guard state machine
  // ----------------------------------------------------------------
  logic guard_sel, guard_fault, lvl_lo, lvl_hi, dly_done, trip_now;
  logic [SPW-1:0] cur_lim, new_lim;
  assign guard_sel = i_guard_sel_di || i_guard_sel_bus;
  assign cur_lim = lim_of(i_level_limits, lvl_q);
  assign new_lim = lim_of(i_level_limits, i_bus_level);
  assign lvl_lo = i_guard_sel_bus && new_lim < cur_lim;
  assign lvl_hi = i_guard_sel_bus && new_lim > cur_lim;
  assign dly_done = cnt_q >= dly_q;
  assign guard_fault = st_q inside {SLSG_LEVEL, SLSG_RAMP} &&
                       i_monitor_fault;
  assign trip_now = i_stop_active && i_monitor_fault;

  always_comb begin
    st_d = st_q;
    lvl_d = lvl_q;
    cnt_d = (cnt_q == 32'hffff_ffff) ? cnt_q : cnt_q + 32'h1;
    bcnt_d = (bcnt_q == 32'hffff_ffff) ? bcnt_q : bcnt_q + 32'h1;
    sel_d = guard_sel;
    brk_d = brk_q;
    ev = '0;
    unique case (st_q)
      SLSG_IDLE: begin
        if (guard_sel) begin
          cnt_d = 32'h0;
          brk_d = i_speed_abs > cur_lim;
          st_d = SLSG_WAIT;
        end
      end
      SLSG_WAIT: begin
        if (dly_done) begin
          bcnt_d = 32'h0;
          st_d = (cfg_q[CFG_RAMP_SUP] && brk_q) ? SLSG_RAMP : SLSG_LEVEL;
        end
      end
      SLSG_RAMP: begin
        if (i_ramp_value <= cur_lim ||
            (i_speed_abs <= cur_lim && bcnt_q >= brd_q)) begin
          st_d = SLSG_LEVEL;
          brk_d = 1'b0;
        end
      end
      SLSG_LEVEL: begin
        if (i_speed_abs <= cur_lim) brk_d = 1'b0;
      end
      SLSG_TRIP: ;
      default: st_d = SLSG_IDLE;
    endcase
    if (st_q inside {SLSG_WAIT, SLSG_RAMP, SLSG_LEVEL}) begin
      if (lvl_lo) begin
        lvl_d = i_bus_level;
        cnt_d = 32'h0;
        brk_d = 1'b1;
        st_d = SLSG_WAIT;
        ev[IRQ_LVL] = 1'b1;
      end else if (lvl_hi) begin
        lvl_d = i_bus_level;
        ev[IRQ_LVL] = 1'b1;
      end
    end
    if (guard_fault || (st_q != SLSG_IDLE && i_coast_stop)) begin
      st_d = SLSG_TRIP;
      ev[IRQ_TCUT] = 1'b1;
    end
    ev[IRQ_FAULT] = guard_fault || trip_now;
    if (!guard_sel) begin
      st_d = SLSG_IDLE;
      brk_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= SLSG_IDLE;
      lvl_q <= 2'b00;
      cnt_q <= 32'h0;
      bcnt_q <= 32'h0;
      sel_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      bcnt_q <= bcnt_d;
      sel_q <= sel_d;
      brk_q <= brk_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic tn_q, tr_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tn_q <= 1'b0;
      tr_q <= 1'b0;
    end else if (i_ce) begin
      // held until both guard and stop function deselected; restart is remote
      tn_q <= trip_now || (tn_q && i_stop_active) ||
              (st_d == SLSG_TRIP &&
              (i_coast_stop || !cfg_q[CFG_STOPB] || tn_q));
      tr_q <= st_d == SLSG_TRIP && !i_coast_stop && cfg_q[CFG_STOPB] &&
              !tn_q;
    end
  end
  assign o_torque_off_now = tn_q;
  assign o_torque_off_ramped = tr_q;
  assign o_run_enable = i_run_command && !tn_q && !tr_q;
  assign o_speed_clamp = st_q != SLSG_IDLE;
  assign o_brake_quick = brk_q;
  assign o_monitor_level = st_q == SLSG_LEVEL;
  assign o_monitor_ramp = st_q == SLSG_RAMP;
  assign o_limit = cur_lim;
  assign o_active_level = lvl_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_stop_fault;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_stop_active && i_monitor_fault |=> o_torque_off_now;
  endproperty
  a_stop_fault: assert property (p_stop_fault)
    else $error("stop fault without torque cut");
  property p_deselect;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_guard_sel_di && !i_guard_sel_bus |=>
      !o_speed_clamp && !o_monitor_level && !o_monitor_ramp;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("guard still clamping after deselect");
  property p_no_early_mon;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_monitor_level && !$past(o_monitor_level) && !$past(o_monitor_ramp)
      |-> $past(cnt_q) >= $past(dly_q);
  endproperty
  a_no_early_mon: assert property (p_no_early_mon)
    else $error("monitoring began before delay");
  property p_level_up;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_monitor_level && lvl_hi && guard_sel && !guard_fault
      && !i_coast_stop |=> o_monitor_level &&
      o_active_level == $past(i_bus_level);
  endproperty
  a_level_up: assert property (p_level_up)
    else $error("higher level not immediate");
  property p_coast;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_speed_clamp && i_coast_stop && guard_sel |=> o_torque_off_now;
  endproperty
  a_coast: assert property (p_coast)
    else $error("coast stop did not cut torque");
  property p_di_no_level;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_guard_sel_bus |=> o_active_level == $past(o_active_level);
  endproperty
  a_di_no_level: assert property (p_di_no_level)
    else $error("level changed without bus word");
  property p_ramp_cfg;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_monitor_ramp && !$past(o_monitor_ramp) |->
      $past(cfg_q[CFG_RAMP_SUP]);
  endproperty
  a_ramp_cfg: assert property (p_ramp_cfg)
    else $error("ramp monitor without supervision");
  property p_run_free;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_speed_clamp && !o_torque_off_now && !o_torque_off_ramped
      |-> o_run_enable == i_run_command;
  endproperty
  a_run_free: assert property (p_run_free)
    else $error("run blocked while guard off");
  c_sel: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_speed_clamp ##[1:20] o_monitor_level);
  c_ramp: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_monitor_ramp ##1 o_monitor_level);
  c_trip: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_torque_off_ramped);
endmodule

// ---- sim/slsg_ctrl_model.sv ----
`timescale 1ns/10ps
module slsg_ctrl_model (
  input wire logic i_clk,
  output logic o_sel_di,
  output logic o_sel_bus,
  output logic [1:0] o_level,
  output logic o_stop,
  output logic o_coast,
  output logic o_run
);
  initial begin
    o_sel_di = 1'b0;
    o_sel_bus = 1'b0;
    o_level = 2'h0;
    o_stop = 1'b0;
    o_coast = 1'b0;
    o_run = 1'b0;
  end
  // ----------
  // selection and commands
  // ----------
  // level request travels with the bus word
  task automatic sel(input logic di, input logic bus, input logic [1:0] lv);
    @(posedge i_clk);
    o_sel_di <= di;
    o_sel_bus <= bus;
    o_level <= lv;
  endtask
  task automatic cmd(input logic stop, input logic coast, input logic run);
    @(posedge i_clk);
    o_stop <= stop;
    o_coast <= coast;
    o_run <= run;
  endtask
  // deselect stop, run low, run high; no acknowledge step here
  task automatic restart();
    cmd(1'b0, o_coast, o_run);
    cmd(1'b0, o_coast, 1'b0);
    // standard acknowledge sits outside this block
    cmd(1'b0, o_coast, 1'b1);
  endtask
endmodule

// ---- sim/slsg_top_tb.sv ----
`timescale 1ns/10ps
module slsg_top_tb;
  import slsg_pkg::*;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, errb, fault;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, flg;
  logic [15:0] speed, ramp, lim;
  logic sdi, sbus, stop, coast, run, ce;
  logic [1:0] lvl, act;
  logic run_en, clamp, brake, mlvl, mramp, t_now, t_ramp, irq;
  int failures = 0;
  int num_checks = 0;
  int cyc_n = 0;
  localparam logic [63:0] LIMS = 64'h0400_0300_0200_0100;
  assign flg = {24'h0, run_en, clamp, brake, mlvl, mramp, t_now, t_ramp, irq};
  slsg_ctrl_model m (.i_clk(clk), .o_sel_di(sdi), .o_sel_bus(sbus),
    .o_level(lvl), .o_stop(stop), .o_coast(coast), .o_run(run));
  slsg_top #(.SPW(16)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_guard_sel_di(sdi), .i_guard_sel_bus(sbus), .i_bus_level(lvl),
    .i_stop_active(stop), .i_monitor_fault(fault), .i_coast_stop(coast),
    .i_speed_abs(speed), .i_ramp_value(ramp), .i_level_limits(LIMS),
    .i_run_command(run), .o_run_enable(run_en), .o_speed_clamp(clamp),
    .o_brake_quick(brake), .o_monitor_level(mlvl), .o_monitor_ramp(mramp),
    .o_limit(lim), .o_torque_off_now(t_now), .o_torque_off_ramped(t_ramp),
    .o_active_level(act), .o_irq(irq)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // -------------
  // bench helpers
  // -------------
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard: far above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e, input logic [31:0] k = '1);
    num_checks++;
    if ((s & k) !== (e & k)) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e & k, s & k);
    end
  endtask
  // settle on the falling edge so sampling never races the design
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no cycle limit here: only the hang guard ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    errb = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // ---------
  // sequence
  // ---------
  initial begin
    {psel, pen, pwr, fault} = 4'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    speed = 16'h0080;
    ramp = 16'hffff;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_DELAY, 32'h0);
    chk("delay", rd, DELAY_RST);
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg", rd, CFG_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {rd[30:0], errb}, 32'h1);
    apb(1'b1, OFS_DELAY, 32'h4);
    apb(1'b1, OFS_BRDELAY, 32'h4);
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    apb(1'b1, OFS_DELAY, 32'h9);
    ce <= 1'b1;
    apb(1'b0, OFS_DELAY, 32'h0);
    chk("ce hold", rd, 32'h4);
    m.cmd(1'b0, 1'b0, 1'b1);
    wt(2);
    chk("free run", flg, 32'h80, 32'hc0);
    m.sel(1'b1, 1'b0, 2'h0);
    wt(1);
    chk("sel slow", flg, 32'hc0, 32'hf8);
    wt(8);
    chk("mon slow", flg, 32'hd0, 32'hf8);
    m.sel(1'b1, 1'b0, 2'h3);
    wt(2);
    chk("di level", {30'h0, act}, 32'h0);
    m.sel(1'b0, 1'b0, 2'h0);
    wt(2);
    chk("deselect", flg, 32'h0, 32'h78);
    @(posedge clk);
    speed <= 16'h0250;
    m.sel(1'b0, 1'b1, 2'h0);
    wt(1);
    chk("sel fast", flg, 32'h60, 32'h70);
    wt(8);
    chk("mon fast", flg, 32'h10, 32'h18);
    m.sel(1'b0, 1'b1, 2'h2);
    wt(2);
    chk("up level", {30'h0, act}, 32'h2);
    chk("up limit", {16'h0, lim}, 32'h0300);
    m.sel(1'b0, 1'b1, 2'h1);
    wt(9);
    chk("down limit", {16'h0, lim}, 32'h0200);
    chk("down mon", flg, 32'h10, 32'h18);
    m.sel(1'b0, 1'b0, 2'h0);
    apb(1'b1, OFS_CFG, 32'h1);
    m.sel(1'b0, 1'b1, 2'h3);
    wt(8);
    m.sel(1'b0, 1'b1, 2'h0);
    wt(1);
    chk("ramp brake", flg, 32'h20, 32'h20);
    wt(8);
    chk("ramp mon", flg, 32'h08, 32'h18);
    @(posedge clk);
    ramp <= 16'h0100;
    wt(3);
    chk("handover", flg, 32'h10, 32'h18);
    m.sel(1'b0, 1'b0, 2'h0);
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    apb(1'b1, OFS_CFG, 32'h2);
    speed <= 16'h0080;
    m.sel(1'b0, 1'b1, 2'h0);
    wt(8);
    @(posedge clk);
    fault <= 1'b1;
    wt(2);
    chk("ramped cut", flg, 32'h02, 32'h87);
    @(posedge clk);
    fault <= 1'b0;
    apb(1'b1, OFS_IRQ_EN, 32'h7);
    wt(1);
    chk("irq on", flg, 32'h1, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq stat", rd, 32'h3, 32'h3);
    m.sel(1'b0, 1'b0, 2'h0);
    wt(2);
    chk("cut cleared", flg, 32'h0, 32'h02);
    m.sel(1'b0, 1'b1, 2'h0);
    wt(8);
    m.cmd(1'b0, 1'b1, 1'b1);
    wt(2);
    chk("coast", flg, 32'h04, 32'h84);
    m.cmd(1'b0, 1'b0, 1'b1);
    m.sel(1'b0, 1'b0, 2'h0);
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    wt(1);
    chk("irq off", flg, 32'h0, 32'h1);
    m.cmd(1'b1, 1'b0, 1'b1);
    fault <= 1'b1;
    wt(2);
    chk("stop fault", flg, 32'h04, 32'h84);
    @(posedge clk);
    fault <= 1'b0;
    wt(2);
    chk("stop held", flg, 32'h04, 32'h84);
    m.restart();
    wt(2);
    chk("restart", flg, 32'h80, 32'h84);
    final_report();
  end
endmodule
